// ---- design/npic_defs.svh ----
`ifndef NPIC_DEFS_SVH
`define NPIC_DEFS_SVH

// ********************************
// Register offsets
// ********************************
`define NPIC_OFS_SET_EN 8'h00
`define NPIC_OFS_CLR_EN 8'h04
`define NPIC_OFS_CLR_PEND 8'h08
`define NPIC_OFS_PRIO_BASE 8'h10
`define NPIC_OFS_PRIO_LAST 8'h2c
`define NPIC_OFS_VTOR 8'h30
`define NPIC_OFS_STAT 8'h34
`define NPIC_OFS_STAT_CLR 8'h38
`define NPIC_OFS_INT_EN 8'h3c
`define NPIC_OFS_STATE 8'h40

// ********************************
// Fields and reset values
// ********************************
`define NPIC_PRIO_LSB 6
`define NPIC_PRIO_RSVD 32'h3f3f_3f3f
`define NPIC_VTOR_RST 32'h0000_0000
`define NPIC_VTOR_MASK 32'hffff_ff00
`define NPIC_EV_ENTER 0
`define NPIC_EV_RETURN 1
`define NPIC_EV_CHAIN 2
`define NPIC_STATE_BUSY 8

// ********************************
// Sources and vectors
// ********************************
`define NPIC_NUM_PERIPH 32
`define NPIC_NUM_SYS 5
`define NPIC_PERIPH_VEC0 6'h10
`define NPIC_VEC_NMI 6'h02
`define NPIC_VEC_HARD 6'h03
`define NPIC_VEC_SVC 6'h0b
`define NPIC_VEC_PENDSRV 6'h0e
`define NPIC_VEC_TICK 6'h0f

// ********************************
// Latencies in core clock cycles
// ********************************
`define NPIC_RET_CYC 4'hf
`define NPIC_CHAIN_CYC 4'hb

`endif

// ---- design/npic_pkg.sv ----
package npic_pkg;

  // ********************************
  // Types
  // ********************************
  typedef logic [1:0] npic_prio_t;

  typedef enum logic [1:0] {
    st_idle,
    st_active,
    st_return,
    st_chain
  } npic_state_t;

endpackage : npic_pkg

// ---- design/npic_arb_if.sv ----
`timescale 1ns/1ns

interface npic_arb_if;
  logic [31:0] req;
  npic_pkg::npic_prio_t [31:0] prio;
  logic [4:0] sys_req;
  logic win_valid;
  logic win_sys;
  logic [4:0] win_idx;
  logic [5:0] win_vec;
  npic_pkg::npic_prio_t win_prio;

  modport ctrl (
    output req, prio, sys_req,
    input win_valid, win_sys, win_idx, win_vec, win_prio
  );

  modport arb (
    input req, prio, sys_req,
    output win_valid, win_sys, win_idx, win_vec, win_prio
  );
endinterface : npic_arb_if

// ---- design/npic_arb.sv ----
`timescale 1ns/1ns
`include "npic_defs.svh"

module npic_arb (
  // Arbitration port
  npic_arb_if.arb bus
);

  // ********************************
  // Most urgent request
  // ********************************
  logic [2:0] best;
  logic [4:0] pidx;
  logic [2:0] sidx;

  always_comb begin
    best = 3'h4;
    pidx = 5'h00;
    sidx = 3'h0;
    for (int i = 0; i < `NPIC_NUM_PERIPH; i++) begin
      if (bus.req[i] && ({1'b0, bus.prio[i]} < best)) begin
        best = {1'b0, bus.prio[i]};
        pidx = 5'(i);
      end
    end
    for (int s = `NPIC_NUM_SYS - 1; s >= 0; s--) begin
      if (bus.sys_req[s]) begin
        sidx = 3'(s);
      end
    end
  end

  always_comb begin
    bus.win_sys = |bus.sys_req;
    bus.win_valid = bus.win_sys || (best != 3'h4);
    bus.win_idx = bus.win_sys ? {2'h0, sidx} : pidx;
    bus.win_prio = bus.win_sys ? 2'h0 : best[1:0];
    if (bus.win_sys) begin
      case (sidx)
        3'h0: bus.win_vec = `NPIC_VEC_NMI;
        3'h1: bus.win_vec = `NPIC_VEC_HARD;
        3'h2: bus.win_vec = `NPIC_VEC_SVC;
        3'h3: bus.win_vec = `NPIC_VEC_PENDSRV;
        default: bus.win_vec = `NPIC_VEC_TICK;
      endcase
    end else begin
      bus.win_vec = {1'b0, pidx} + `NPIC_PERIPH_VEC0;
    end
  end

endmodule : npic_arb

// ---- design/npic_ctrl.sv ----
`timescale 1ns/1ns
`include "npic_defs.svh"

module npic_ctrl (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Requests
  input wire logic [31:0] periph_irq,
  input wire logic [4:0] sys_exc_req,
  // Core handshake
  input wire logic hndl_done,
  output logic hndl_enter,
  output logic hndl_return,
  output logic [5:0] vec_num,
  output logic [31:0] vec_addr,
  // Interrupt
  output logic irq_out
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  // ********************************
  // Arbiter
  // ********************************
  npic_arb_if arb_if ();

  npic_arb u_arb (
    .bus(arb_if)
  );

  // ********************************
  // Decode
  // ********************************
  logic wr_set_en;
  logic wr_clr_en;
  logic wr_clr_pend;
  logic wr_prio;
  logic rd_prio;
  logic [7:0] prio_off;
  logic [2:0] prio_word;

  assign wr_set_en = reg_wr && (reg_addr == `NPIC_OFS_SET_EN);
  assign wr_clr_en = reg_wr && (reg_addr == `NPIC_OFS_CLR_EN);
  assign wr_clr_pend = reg_wr && (reg_addr == `NPIC_OFS_CLR_PEND);
  assign rd_prio = (reg_addr >= `NPIC_OFS_PRIO_BASE) &&
                   (reg_addr <= `NPIC_OFS_PRIO_LAST) &&
                   (reg_addr[1:0] == 2'h0);
  assign wr_prio = reg_wr && rd_prio;
  assign prio_off = reg_addr - `NPIC_OFS_PRIO_BASE;
  assign prio_word = prio_off[4:2];

  // ********************************
  // Configuration registers
  // ********************************
  logic [31:0] en_ff;
  logic [31:0] nxt_en;
  npic_pkg::npic_prio_t [31:0] prio_ff;
  npic_pkg::npic_prio_t [31:0] nxt_prio;
  logic [31:0] vtor_ff;
  logic [31:0] nxt_vtor;
  logic [2:0] int_en_ff;
  logic [2:0] nxt_int_en;

  always_comb begin
    nxt_en = en_ff;
    nxt_prio = prio_ff;
    nxt_vtor = vtor_ff;
    nxt_int_en = int_en_ff;
    if (wr_set_en) begin
      nxt_en = en_ff | reg_wdata;
    end
    if (wr_clr_en) begin
      nxt_en = en_ff & ~reg_wdata;
    end
    if (wr_prio) begin
      for (int b = 0; b < 4; b++) begin
        nxt_prio[int'(prio_word) * 4 + b] =
          reg_wdata[8 * b + `NPIC_PRIO_LSB +: 2];
      end
    end
    if (reg_wr && (reg_addr == `NPIC_OFS_VTOR)) begin
      nxt_vtor = reg_wdata & `NPIC_VTOR_MASK;
    end
    if (reg_wr && (reg_addr == `NPIC_OFS_INT_EN)) begin
      nxt_int_en = reg_wdata[2:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      en_ff <= 32'h0000_0000;
      prio_ff <= '0;
      vtor_ff <= `NPIC_VTOR_RST;
      int_en_ff <= 3'h0;
    end else begin
      en_ff <= nxt_en;
      prio_ff <= nxt_prio;
      vtor_ff <= nxt_vtor;
      int_en_ff <= nxt_int_en;
    end
  end

  // ********************************
  // Pending flags
  // ********************************
  logic [31:0] pend_ff;
  logic [31:0] nxt_pend;
  logic [4:0] spend_ff;
  logic [4:0] nxt_spend;
  logic [31:0] clr_entry;
  logic [4:0] sclr_entry;

  always_comb begin
    nxt_pend = pend_ff & ~clr_entry;
    if (wr_clr_pend) begin
      nxt_pend = nxt_pend & ~reg_wdata;
    end
    nxt_pend = nxt_pend | periph_irq;
    nxt_spend = (spend_ff & ~sclr_entry) | sys_exc_req;
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pend_ff <= 32'h0000_0000;
      spend_ff <= 5'h00;
    end else begin
      pend_ff <= nxt_pend;
      spend_ff <= nxt_spend;
    end
  end
  assign arb_if.req = pend_ff & en_ff;
  assign arb_if.prio = prio_ff;
  assign arb_if.sys_req = spend_ff;
  // ********************************
  // Entry and exit sequencer
  // ********************************
  npic_pkg::npic_state_t state_ff;
  npic_pkg::npic_state_t nxt_state;
  logic [3:0] cnt_ff;
  logic [3:0] nxt_cnt;
  logic enter_ff;
  logic nxt_enter;
  logic return_ff;
  logic nxt_return;
  logic [5:0] vec_ff;
  logic [5:0] nxt_vec;
  logic [31:0] addr_ff;
  logic [31:0] nxt_addr;
  logic take;
  logic chain_ev;
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_return = 1'b0;
    take = 1'b0;
    chain_ev = 1'b0;
    case (state_ff)
      npic_pkg::st_idle: begin
        if (arb_if.win_valid) begin
          take = 1'b1;
          nxt_state = npic_pkg::st_active;
        end
      end
      npic_pkg::st_active: begin
        if (hndl_done) begin
          nxt_cnt = 4'h1;
          if (arb_if.win_valid) begin
            chain_ev = 1'b1;
            nxt_state = npic_pkg::st_chain;
          end else begin
            nxt_state = npic_pkg::st_return;
          end
        end
      end
      npic_pkg::st_return: begin
        if (cnt_ff == `NPIC_RET_CYC - 4'h1) begin
          nxt_return = 1'b1;
          nxt_state = npic_pkg::st_idle;
        end else begin
          nxt_cnt = cnt_ff + 4'h1;
        end
      end
      npic_pkg::st_chain: begin
        if (cnt_ff == `NPIC_CHAIN_CYC - 4'h1) begin
          if (arb_if.win_valid) begin
            take = 1'b1;
            nxt_state = npic_pkg::st_active;
          end else begin
            nxt_return = 1'b1;
            nxt_state = npic_pkg::st_idle;
          end
        end else begin
          nxt_cnt = cnt_ff + 4'h1;
        end
      end
      default: begin
        nxt_state = npic_pkg::st_idle;
      end
    endcase
  end
  always_comb begin
    nxt_enter = take;
    nxt_vec = vec_ff;
    nxt_addr = addr_ff;
    clr_entry = 32'h0000_0000;
    sclr_entry = 5'h00;
    if (take) begin
      nxt_vec = arb_if.win_vec;
      nxt_addr = vtor_ff + {24'h00_0000, arb_if.win_vec, 2'h0};
      if (arb_if.win_sys) begin
        sclr_entry[arb_if.win_idx[2:0]] = 1'b1;
      end else begin
        clr_entry[arb_if.win_idx] = 1'b1;
      end
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_ff <= npic_pkg::st_idle;
      cnt_ff <= 4'h0;
      enter_ff <= 1'b0;
      return_ff <= 1'b0;
      vec_ff <= 6'h00;
      addr_ff <= 32'h0000_0000;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      enter_ff <= nxt_enter;
      return_ff <= nxt_return;
      vec_ff <= nxt_vec;
      addr_ff <= nxt_addr;
    end
  end
  assign hndl_enter = enter_ff;
  assign hndl_return = return_ff;
  assign vec_num = vec_ff;
  assign vec_addr = addr_ff;
  // ********************************
  // Event status and interrupt
  // ********************************
  logic [2:0] stat_ff;
  logic [2:0] nxt_stat;
  logic [2:0] events;
  always_comb begin
    events = 3'h0;
    events[`NPIC_EV_ENTER] = nxt_enter;
    events[`NPIC_EV_RETURN] = nxt_return;
    events[`NPIC_EV_CHAIN] = chain_ev;
    nxt_stat = stat_ff;
    if (reg_wr && (reg_addr == `NPIC_OFS_STAT_CLR)) begin
      nxt_stat = stat_ff & ~reg_wdata[2:0];
    end
    nxt_stat = nxt_stat | events;
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      stat_ff <= 3'h0;
    end else begin
      stat_ff <= nxt_stat;
    end
  end
  assign irq_out = |(stat_ff & int_en_ff);
  // ********************************
  // Read data
  // ********************************
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic [31:0] rd_val;
  always_comb begin
    rd_val = 32'h0000_0000;
    if (rd_prio) begin
      for (int b = 0; b < 4; b++) begin
        rd_val[8 * b + `NPIC_PRIO_LSB +: 2] =
          prio_ff[int'(prio_word) * 4 + b];
      end
    end else begin
      case (reg_addr)
        `NPIC_OFS_SET_EN: rd_val = en_ff;
        `NPIC_OFS_CLR_EN: rd_val = en_ff;
        `NPIC_OFS_CLR_PEND: rd_val = pend_ff;
        `NPIC_OFS_VTOR: rd_val = vtor_ff;
        `NPIC_OFS_STAT: rd_val = {29'h0000_0000, stat_ff};
        `NPIC_OFS_INT_EN: rd_val = {29'h0000_0000, int_en_ff};
        `NPIC_OFS_STATE: begin
          rd_val[5:0] = vec_ff;
          rd_val[`NPIC_STATE_BUSY] = (state_ff != npic_pkg::st_idle);
        end
        default: rd_val = 32'h0000_0000;
      endcase
    end
    nxt_rdata = reg_rd ? rd_val : 32'h0000_0000;
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rdata_ff <= 32'h0000_0000;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end
  assign reg_rdata = rdata_ff;
  // ********************************
  // Checks
  // ********************************
  logic more_urgent;
  always_comb begin
    more_urgent = 1'b0;
    for (int i = 0; i < `NPIC_NUM_PERIPH; i++) begin
      if (arb_if.req[i] && (arb_if.prio[i] < arb_if.win_prio)) begin
        more_urgent = 1'b1;
      end
    end
  end
  a_return_latency: assert property (
    (state_ff == npic_pkg::st_active && hndl_done && !arb_if.win_valid)
    |-> !hndl_return [*8] ##8 hndl_return)
    else $error("handler return not 15 cycles after done");
  a_chain_latency: assert property (
    (state_ff == npic_pkg::st_active && hndl_done && arb_if.win_valid)
    |-> !hndl_enter [*8] ##4 (hndl_enter || hndl_return))
    else $error("tail chain not 11 cycles after done");
  a_prio_order: assert property (
    (arb_if.win_valid && !arb_if.win_sys) |-> !more_urgent)
    else $error("less urgent request won arbitration");
  a_sys_first: assert property (
    (|spend_ff) |-> (arb_if.win_sys && arb_if.win_vec < `NPIC_PERIPH_VEC0))
    else $error("core exception not preferred");
  a_enter_vec: assert property (
    (state_ff == npic_pkg::st_idle && arb_if.win_valid)
    |=> (hndl_enter && vec_num == $past(arb_if.win_vec)))
    else $error("pending enabled request not vectored");
  a_vec_addr: assert property (
    hndl_enter |-> (vec_addr == $past(vtor_ff) + {24'h00_0000, vec_num, 2'h0}))
    else $error("vector address not taken from table base");
  a_prio_rsvd: assert property (
    (reg_rd && rd_prio) |=> ((reg_rdata & `NPIC_PRIO_RSVD) == 32'h0000_0000))
    else $error("reserved priority bits read nonzero");
  a_clr_pend: assert property (
    (wr_clr_pend && reg_wdata[1] && !periph_irq[1] && !clr_entry[1])
    |=> !pend_ff[1])
    else $error("clear pending write did not clear");
  a_set_enable: assert property (
    (wr_set_en && reg_wdata[1]) |=> en_ff[1])
    else $error("set enable write did not enable");
endmodule : npic_ctrl

// ---- testbench/npic_core_model.sv ----
`timescale 1ns/1ns

// ********************************
// Core side model
// ********************************
module npic_core_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Handshake
  input wire logic hndl_enter,
  input wire logic [7:0] svc_cycles,
  output logic hndl_done
);
  logic busy_ff;
  logic [7:0] cnt_ff;

  // Runs each entered handler for svc_cycles, then reports it finished
  always @(posedge clk_sys) begin
    hndl_done <= rst_n && !hndl_enter && busy_ff && (cnt_ff == 8'h00);
    if (!rst_n) begin
      busy_ff <= 1'b0;
      cnt_ff <= 8'h00;
    end else if (hndl_enter) begin
      busy_ff <= 1'b1;
      cnt_ff <= svc_cycles;
    end else if (busy_ff && cnt_ff == 8'h00) begin
      busy_ff <= 1'b0;
    end else if (busy_ff) begin
      cnt_ff <= cnt_ff - 8'h01;
    end
  end
endmodule : npic_core_model

// ---- testbench/npic_ctrl_test.sv ----
`timescale 1ns/1ns

module npic_ctrl_test;
  logic clk_sys;
  logic rst_n;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic [31:0] periph_irq;
  logic [4:0] sys_exc_req;
  logic hndl_done;
  logic hndl_enter;
  logic hndl_return;
  logic [5:0] vec_num;
  logic [31:0] vec_addr;
  logic irq_out;
  logic [7:0] svc_cycles;
  int fail_count;
  int compares;
  int cyc = 0;
  int t_done = 0;
  logic [5:0] sys_vec [5] = '{6'h02, 6'h03, 6'h0b, 6'h0e, 6'h0f};

  // ********************************
  // Design and core model
  // ********************************
  npic_ctrl dut_u (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .periph_irq(periph_irq),
    .sys_exc_req(sys_exc_req),
    .hndl_done(hndl_done),
    .hndl_enter(hndl_enter),
    .hndl_return(hndl_return),
    .vec_num(vec_num),
    .vec_addr(vec_addr),
    .irq_out(irq_out)
  );

  npic_core_model core_u (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .hndl_enter(hndl_enter),
    .svc_cycles(svc_cycles),
    .hndl_done(hndl_done)
  );

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // Cycle count and moment of the last finished handler
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (hndl_done === 1'b1) begin
      t_done <= cyc;
    end
  end

  // ********************************
  // Tasks
  // ********************************
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(posedge clk_sys);
    chk($sformatf("reg_rdata at %h", a), exp, reg_rdata);
  endtask : rd_chk

  task automatic pulse(input logic [31:0] p, input logic [4:0] s);
    periph_irq <= p;
    sys_exc_req <= s;
    @(posedge clk_sys);
    periph_irq <= 32'h0000_0000;
    sys_exc_req <= 5'h00;
  endtask : pulse

  // Waits for an entry or a return; lat of zero skips the latency check
  task automatic wait_evt(input logic want_enter, input logic [5:0] ev,
                          input int lat);
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (hndl_enter !== 1'b1 && hndl_return !== 1'b1 && n < 200);
    chk("handler event", 32'h1, {31'h0, hndl_enter | hndl_return});
    chk("hndl_enter", {31'h0, want_enter}, {31'h0, hndl_enter});
    if (want_enter) begin
      chk("vec_num", {26'h0, ev}, {26'h0, vec_num});
      chk("vec_addr", 32'h2000_0000 + {24'h0, ev, 2'b00}, vec_addr);
    end
    if (lat > 0) begin
      chk("latency", lat, cyc - t_done);
    end
  endtask : wait_evt

  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask : end_test

  task automatic final_report;
    $display("checks %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report

  initial begin
    repeat (5000) @(posedge clk_sys);
    fail_count++;
    $display("watchdog expired");
    final_report();
  end

  // ********************************
  // Tests
  // ********************************
  initial begin
    rst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    periph_irq = 32'h0000_0000;
    sys_exc_req = 5'h00;
    svc_cycles = 8'h03;
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    rd_chk(8'h30, 32'h0000_0000);
    rd_chk(8'h00, 32'h0000_0000);
    rd_chk(8'h10, 32'h0000_0000);
    rd_chk(8'h40, 32'h0000_0000);
    end_test("reset values");
    wr(8'h00, 32'h0000_0006);
    rd_chk(8'h00, 32'h0000_0006);
    wr(8'h10, 32'h0f4f_ff0f);
    rd_chk(8'h10, 32'h0040_c000);
    wr(8'h2c, 32'hffff_ffff);
    rd_chk(8'h2c, 32'hc0c0_c0c0);
    wr(8'h30, 32'h2000_0055);
    rd_chk(8'h30, 32'h2000_0000);
    wr(8'h44, 32'hffff_ffff);
    rd_chk(8'h44, 32'h0000_0000);
    rd_chk(8'h31, 32'h0000_0000);
    end_test("registers");
    pulse(32'h0000_0020, 5'h00);
    rd_chk(8'h08, 32'h0000_0020);
    wr(8'h08, 32'h0000_0000);
    rd_chk(8'h08, 32'h0000_0020);
    wr(8'h08, 32'h0000_0020);
    rd_chk(8'h08, 32'h0000_0000);
    end_test("clear pending");
    wr(8'h38, 32'h0000_0007);
    wr(8'h3c, 32'h0000_0001);
    pulse(32'h0000_0006, 5'h00);
    wait_evt(1'b1, 6'd18, 0);
    wait_evt(1'b1, 6'd17, 11);
    wait_evt(1'b0, 6'd0, 15);
    rd_chk(8'h34, 32'h0000_0007);
    rd_chk(8'h08, 32'h0000_0000);
    chk("irq_out", 32'h1, {31'h0, irq_out});
    wr(8'h3c, 32'h0000_0000);
    @(posedge clk_sys);
    chk("irq_out", 32'h0, {31'h0, irq_out});
    wr(8'h38, 32'h0000_0007);
    rd_chk(8'h34, 32'h0000_0000);
    end_test("priority and chaining");
    svc_cycles <= 8'd40;
    for (int i = 0; i < 5; i++) begin
      pulse(32'h0000_0000, 5'h01 << i);
      wait_evt(1'b1, sys_vec[i], 0);
      rd_chk(8'h40, {23'h0, 1'b1, 2'h0, sys_vec[i]});
      wait_evt(1'b0, 6'd0, 15);
    end
    end_test("core exceptions");
    wr(8'h04, 32'h0000_0006);
    rd_chk(8'h00, 32'h0000_0000);
    pulse(32'h0000_0002, 5'h00);
    repeat (4) @(posedge clk_sys);
    rd_chk(8'h08, 32'h0000_0002);
    wr(8'h08, 32'h0000_0002);
    rd_chk(8'h08, 32'h0000_0000);
    end_test("disabled source");
    final_report();
  end
endmodule : npic_ctrl_test
